// >>> pkg/fifo_irq_pkg.sv
// Notes on behaviour
// - Queue interrupt goes to selected pin
// - Interrupt on clock pin overrides clock input
// - Interrupt on pin two overrides output enable
// - Pin two interrupt keeps outputs on in standby
// - Queue off: route data-ready instead
// - Queue control write empties queue only while queue enabled
// - Sync-clear enable makes sync flush queue
// - Sync flush restarts channel sequencer
// - Early transaction discarded, ignore flag set
// - Ignore flag cleared only by writing one
// - Sixty-four ones on data in resets device
// - Serial link uses three wires
// - Queue interrupt is OR of enabled sources
// - Queue interrupt output is active high
package fifo_irq_pkg;

  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned INIT_TIME_US  = 1;
  localparam int unsigned INIT_CYCLES   = (CLK_HZ / 1_000_000) * INIT_TIME_US;
  localparam logic [6:0]  SW_RESET_ONES = 7'h40;

  localparam logic [1:0] PIN_SEL_INT  = 2'h0;
  localparam logic [1:0] PIN_SEL_CLK  = 2'h1;
  localparam logic [1:0] PIN_SEL_GP2  = 2'h2;

  // Word byte addresses
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_QCTRL   = 4'h4;
  localparam logic [3:0] ADDR_QSRC    = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'hC;

  // Control register fields
  localparam int CTRL_PIN_SEL_LSB  = 0;
  localparam int CTRL_CLK_EXT      = 2;
  localparam int CTRL_P2_OE        = 3;
  localparam int CTRL_SYNC_FLUSH   = 4;
  localparam int CTRL_STANDBY      = 5;
  localparam int CTRL_IRQ_MASK_LSB = 8;
  localparam logic [10:0] CTRL_RESET = 11'h000;

  // Queue control fields
  localparam int QCTRL_ENABLE      = 0;
  localparam int QCTRL_SRC_EN_LSB  = 8;
  localparam int NUM_QSRC          = 6;
  localparam logic [13:0] QCTRL_RESET = 14'h0100;

  // Status bits, write one to clear
  localparam int ST_IGNORE     = 0;
  localparam int ST_SW_RESET   = 1;
  localparam int ST_FLUSH      = 2;
  localparam int NUM_ST        = 3;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_n;
  } spi_in_t;

  typedef struct packed {
    logic int_o;
    logic clk_o;
    logic clk_oe;
    logic gp2_o;
    logic gp2_oe;
  } pin_out_t;

endpackage

// >>> design/sync2.sv
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,  // System clock
  input  wire logic         rst_i,  // Sync reset
  input  wire logic [W-1:0] d_i,    // Asynchronous input
  output logic      [W-1:0] q_o     // Synchronised output
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule

// >>> design/pin_router.sv
`timescale 1ns/10ps
module pin_router
  import fifo_irq_pkg::*;
(
  input  wire logic       clk_i,        // System clock
  input  wire logic       rst_i,        // Sync reset
  input  wire logic [1:0] sel_i,        // Pin select
  input  wire logic       sig_i,        // Interrupt or data-ready
  input  wire logic       clk_ext_i,    // Clock pin wanted as input
  input  wire logic       p2_oe_i,      // Pin two output enable
  input  wire logic       p2_val_i,     // Pin two output value
  input  wire logic       standby_i,    // Standby mode
  output fifo_irq_pkg::pin_out_t pins_o // Registered pin drives
);
  pin_out_t nxt;

  always_comb begin
    nxt        = '0;
    nxt.clk_oe = ~clk_ext_i;
    nxt.gp2_oe = p2_oe_i & ~standby_i;
    nxt.gp2_o  = p2_val_i;
    case (sel_i)
      PIN_SEL_INT: begin
        nxt.int_o = sig_i;
      end
      PIN_SEL_CLK: begin
        nxt.clk_o  = sig_i;
        nxt.clk_oe = 1'b1;
      end
      PIN_SEL_GP2: begin
        nxt.gp2_o  = sig_i;
        nxt.gp2_oe = 1'b1;
      end
      default: begin
        nxt.int_o = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) pins_o <= '0;
    else       pins_o <= nxt;
  end
endmodule

// >>> design/fifo_irq_top.sv
`timescale 1ns/10ps
module fifo_irq_top
  import fifo_irq_pkg::*;
(
  input  wire logic        clk_i,         // System clock 50 MHz
  input  wire logic        rst_i,         // Sync reset, active high
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,      // Cycle
  input  wire logic        wb_stb_i,      // Strobe
  input  wire logic        wb_we_i,       // Write enable
  input  wire logic [3:0]  wb_adr_i,      // Byte address
  input  wire logic [3:0]  wb_sel_i,      // Byte selects
  input  wire logic [31:0] wb_dat_i,      // Write data
  output logic      [31:0] wb_dat_o,      // Read data
  output logic             wb_ack_o,      // Acknowledge
  output logic             irq_o,         // Level interrupt
  // Serial link pins
  input  wire fifo_irq_pkg::spi_in_t spi_i, // Clock, data in, select
  input  wire logic        sync_n_i,      // Sync pin, active low
  // Queue side
  input  wire logic [5:0]  qsrc_i,        // Queue interrupt sources
  input  wire logic        drdy_i,        // Conversion data ready
  input  wire logic        p2_val_i,      // Pin two GPO value
  output logic             q_flush_o,     // Empty queue pulse
  output logic             seq_restart_o, // Sequencer restart pulse
  output logic             sw_reset_o,    // Full device reset pulse
  output logic             xfer_ok_o,     // Transaction accepted
  output logic             q_enable_o,    // Queue enabled
  // Pins
  output fifo_irq_pkg::pin_out_t pins_o   // INT, CLK, pin two drives
);
  import fifo_irq_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Idle-high pins pass inverted, so the synchroniser's cleared state reads as idle
  // and no false select or sync edge follows reset
  localparam logic [3:0] PIN_IDLE_HI = 4'hB;
  logic [3:0] pin_s;
  sync2 #(.W(4)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({spi_i.sclk, spi_i.mosi, spi_i.cs_n, sync_n_i} ^ PIN_IDLE_HI),
    .q_o   (pin_s)
  );
  logic sclk_s, mosi_s, cs_n_s, sync_n_s;
  assign {sclk_s, mosi_s, cs_n_s, sync_n_s} = pin_s ^ PIN_IDLE_HI;

  //////////////////////////////////////////////////////////////////////
  // Registers
  logic [10:0]        ctrl_r;
  logic [13:0]        qctrl_r;
  logic [NUM_ST-1:0]  status_r;
  logic               ack_r;
  logic [31:0]        rdata_r;

  logic wb_req, wr_ctrl, wr_qctrl, wr_status;
  assign wb_req    = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_ctrl   = wb_req & wb_we_i & (wb_adr_i == ADDR_CTRL);
  assign wr_qctrl  = wb_req & wb_we_i & (wb_adr_i == ADDR_QCTRL);
  assign wr_status = wb_req & wb_we_i & (wb_adr_i == ADDR_STATUS);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction

  logic [31:0] ctrl_m;
  logic [31:0] qctrl_m;
  assign ctrl_m  = merge({21'h0, ctrl_r}, wb_dat_i, wb_sel_i);
  assign qctrl_m = merge({18'h0, qctrl_r}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i || sw_reset_o) ctrl_r <= CTRL_RESET;
    else if (wr_ctrl) ctrl_r <= ctrl_m[10:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sw_reset_o) qctrl_r <= QCTRL_RESET;
    else if (wr_qctrl) qctrl_r <= qctrl_m[13:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          ADDR_CTRL:   rdata_r <= {21'h0, ctrl_r};
          ADDR_QCTRL:  rdata_r <= {18'h0, qctrl_r};
          ADDR_QSRC:   rdata_r <= {26'h0, qsrc_i};
          ADDR_STATUS: rdata_r <= {29'h0, status_r};
          default:     rdata_r <= 32'h0;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  //////////////////////////////////////////////////////////////////////
  // Initialisation wait after any reset
  localparam int CW = $clog2(INIT_CYCLES + 1);
  logic [CW-1:0] init_cnt_r;
  logic          ready_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || sw_reset_o) begin
      init_cnt_r <= '0;
      ready_r    <= 1'b0;
    end else if (!ready_r) begin
      init_cnt_r <= init_cnt_r + 1'b1;
      ready_r    <= (init_cnt_r == CW'(INIT_CYCLES - 1));
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Link watcher: transaction start, ones counter on data in
  logic sclk_d_r, cs_d_r;
  logic [6:0] ones_r;
  logic early_r;
  logic sclk_rise, cs_fall;
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign cs_fall   = cs_d_r & ~cs_n_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_d_r <= 1'b1;
      cs_d_r   <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      cs_d_r   <= cs_n_s;
    end
  end

  // Ones counting works even before init so a stuck device can recover
  always_ff @(posedge clk_i) begin
    if (rst_i || sw_reset_o || cs_n_s) ones_r <= '0;
    else if (sclk_rise) ones_r <= mosi_s ? ones_r + 1'b1 : 7'h0;
  end
  assign sw_reset_o = (ones_r == SW_RESET_ONES);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      early_r   <= 1'b0;
      xfer_ok_o <= 1'b0;
    end else begin
      early_r   <= cs_fall & ~ready_r;
      if (cs_fall) xfer_ok_o <= ready_r;
      else if (cs_n_s) xfer_ok_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sync-pin flush
  logic sync_d_r, sync_fall, sync_flush_r, qwr_flush_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) sync_d_r <= 1'b1;
    else       sync_d_r <= sync_n_s;
  end
  assign sync_fall = sync_d_r & ~sync_n_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_flush_r <= 1'b0;
      qwr_flush_r  <= 1'b0;
    end else begin
      sync_flush_r <= sync_fall & ctrl_r[CTRL_SYNC_FLUSH];
      qwr_flush_r  <= wr_qctrl & qctrl_r[QCTRL_ENABLE];
    end
  end
  assign q_flush_o     = qwr_flush_r | sync_flush_r;
  assign seq_restart_o = sync_flush_r;

  //////////////////////////////////////////////////////////////////////
  // Status and interrupt
  logic [NUM_ST-1:0] ev;
  assign ev = {q_flush_o, sw_reset_o, early_r};
  always_ff @(posedge clk_i) begin
    if (rst_i) status_r <= '0;
    else status_r <= (status_r & ~(wr_status & wb_sel_i[0] ? wb_dat_i[NUM_ST-1:0]
                                  : '0)) | ev;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) irq_o <= 1'b0;
    else irq_o <= |(status_r & ctrl_r[CTRL_IRQ_MASK_LSB +: NUM_ST]);
  end

  //////////////////////////////////////////////////////////////////////
  // Queue interrupt and pin routing
  logic qirq, route_sig;
  assign qirq      = |(qsrc_i & qctrl_r[QCTRL_SRC_EN_LSB +: NUM_QSRC]);
  assign route_sig = qctrl_r[QCTRL_ENABLE] ? qirq : drdy_i;
  assign q_enable_o = qctrl_r[QCTRL_ENABLE];

  pin_router u_route (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .sel_i     (ctrl_r[CTRL_PIN_SEL_LSB +: 2]),
    .sig_i     (route_sig),
    .clk_ext_i (ctrl_r[CTRL_CLK_EXT]),
    .p2_oe_i   (ctrl_r[CTRL_P2_OE]),
    .p2_val_i  (p2_val_i),
    .standby_i (ctrl_r[CTRL_STANDBY]),
    .pins_o    (pins_o)
  );
endmodule

// >>> verif/fifo_irq_assertions.sv
`timescale 1ns/10ps
module fifo_irq_assertions
  import fifo_irq_pkg::*;
(
  input wire logic                   clk_i,         // Clock
  input wire logic                   rst_i,         // Reset
  input wire logic                   wb_cyc_i,      // Cycle
  input wire logic                   wb_stb_i,      // Strobe
  input wire logic                   wb_we_i,       // Write
  input wire logic [3:0]             wb_adr_i,      // Address
  input wire logic                   wb_ack_o,      // Acknowledge
  input wire fifo_irq_pkg::spi_in_t  spi_i,         // Link pins
  input wire logic                   sync_n_i,      // Sync pin
  input wire logic                   drdy_i,        // Data ready
  input wire logic                   q_flush_o,     // Flush pulse
  input wire logic                   seq_restart_o, // Restart pulse
  input wire logic                   sw_reset_o,    // Reset pulse
  input wire logic                   q_enable_o,    // Queue on
  input wire fifo_irq_pkg::pin_out_t pins_o         // Pin drives
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_qwr_flush;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == ADDR_QCTRL && q_enable_o
      |=> q_flush_o;
  endproperty
  a_qwr_flush: assert property (p_qwr_flush) else $error("write did not flush");
  property p_restart_flush; seq_restart_o |-> q_flush_o; endproperty
  a_restart_flush: assert property (p_restart_flush) else $error("restart alone");
  property p_sync_low; seq_restart_o |-> !$past(sync_n_i, 3); endproperty
  a_sync_low: assert property (p_sync_low) else $error("restart without sync");
  property p_sw_frame; sw_reset_o |-> !$past(spi_i.cs_n, 3); endproperty
  a_sw_frame: assert property (p_sw_frame) else $error("reset outside frame");
  // Queue off two cycles: the interrupt pin can only be carrying data-ready
  property p_drdy;
    pins_o.int_o && !q_enable_o && !$past(q_enable_o) |-> $past(drdy_i);
  endproperty
  a_drdy: assert property (p_drdy) else $error("int pin not data ready");
endmodule
bind fifo_irq_top fifo_irq_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .spi_i(spi_i), .sync_n_i(sync_n_i), .drdy_i(drdy_i),
  .q_flush_o(q_flush_o), .seq_restart_o(seq_restart_o), .sw_reset_o(sw_reset_o),
  .q_enable_o(q_enable_o), .pins_o(pins_o));

// >>> verif/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model
  import fifo_irq_pkg::*;
(
  input  wire logic             go_i,   // Start a frame
  input  wire logic [6:0]       n_i,    // Count of one bits
  output fifo_irq_pkg::spi_in_t spi_o,  // Clock, data, select
  output logic                  busy_o  // Frame running
);
  // Idle levels follow the pull-up on clock and select, pull-down on data
  initial begin
    spi_o = '{sclk: 1'b1, mosi: 1'b0, cs_n: 1'b1};
    busy_o = 1'b0;
  end
  // Link clock only toggles inside a frame, 160 ns period
  always @(posedge go_i) begin
    // Keep pin changes off the system clock edge so sampling is repeatable
    #5;
    busy_o = 1'b1;
    spi_o.cs_n = 1'b0;
    #80;
    repeat (n_i) begin
      spi_o.sclk = 1'b0;
      spi_o.mosi = 1'b1;
      #80;
      spi_o.sclk = 1'b1;
      #80;
    end
    #80;
    spi_o.cs_n = 1'b1;
    spi_o.mosi = 1'b0;
    busy_o = 1'b0;
  end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  import fifo_irq_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, sync_n, drdy, p2v, ack, irq, go, busy;
  logic        flush, restart, swr, xok, xs;
  logic [3:0]  adr;
  logic [31:0] wdat, dout, rd;
  logic [5:0]  qsrc;
  logic [6:0]  nbits;
  spi_in_t     spi;
  pin_out_t    pins;
  int          n_errors, checks_done, fl_n, seq_n, sw_n, b;
  fifo_irq_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout),
    .wb_ack_o(ack), .irq_o(irq), .spi_i(spi), .sync_n_i(sync_n), .qsrc_i(qsrc),
    .drdy_i(drdy), .p2_val_i(p2v), .q_flush_o(flush), .seq_restart_o(restart),
    .sw_reset_o(swr), .xfer_ok_o(xok), .q_enable_o(), .pins_o(pins));
  spi_host_model host (.go_i(go), .n_i(nbits), .spi_o(spi), .busy_o(busy));
  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    fl_n += flush;
    seq_n += restart;
    sw_n += swr;
  end
  ////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dout;
    cyc <= 0; stb <= 0;
  endtask
  task frame(input logic [6:0] n);
    @(posedge clk_i); nbits <= n; go <= 1;
    @(posedge clk_i); go <= 0;
    xs = 1'b0;
    do begin
      @(posedge clk_i);
      xs = xs | xok;
    end while (busy);
    settle(4);
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task close_out;
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #300_000; n_errors++; close_out;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, go, drdy, p2v, adr, wdat, qsrc, nbits} = 0;
    sync_n = 1; rst_i = 1;
    void'($urandom(27715));
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    frame(8); // Deliberately too early
    chk("xfer_early", xs, 0);
    wb(0, ADDR_STATUS, 0); chk("early", rd[ST_IGNORE], 1);
    wb(1, ADDR_STATUS, 0); wb(0, ADDR_STATUS, 0); chk("keep", rd[ST_IGNORE], 1);
    wb(1, ADDR_STATUS, 1); wb(0, ADDR_STATUS, 0); chk("w1c", rd[ST_IGNORE], 0);
    frame(63); chk("ones63", sw_n, 0);
    chk("xfer_ok", xs, 1);
    frame(64); chk("ones64", sw_n, 1);
    wb(0, ADDR_STATUS, 0); chk("swst", rd[ST_SW_RESET], 1);
    settle(INIT_CYCLES + 10);
    wb(1, ADDR_CTRL, 0);
    b = fl_n; wb(1, ADDR_QCTRL, 32'h3F01); wb(1, ADDR_QCTRL, ($urandom & 32'h3F00) | 1);
    settle(2); chk("wflush", fl_n - b, 1);
    for (int e = 1; e >= 0; e--) begin
      wb(1, ADDR_CTRL, e << CTRL_SYNC_FLUSH); b = fl_n; sync_n <= 0;
      repeat (10) @(posedge clk_i); sync_n <= 1;
      settle(8); chk("sync", fl_n - b, e);
    end
    chk("restart", seq_n, 1);
    wb(1, ADDR_CTRL, 32'h400); settle(3); chk("irq", irq, 1);
    wb(1, ADDR_STATUS, 32'h4); settle(3); chk("irqclr", irq, 0);
    wb(0, 4'h2, 0); chk("unmap", rd, 0);
    qsrc <= $urandom; wb(0, ADDR_QSRC, 0); chk("qsrc", rd, qsrc);
    wb(1, ADDR_QCTRL, 32'h3F01);
    for (int s = 0; s < 3; s++) begin
      wb(1, ADDR_CTRL, s | 32'h24); qsrc <= $urandom % 63 + 1; p2v <= $urandom; settle(3);
      chk("intpin", pins.int_o, s == 0);
      chk("clkoe", pins.clk_oe, s == 1);
      chk("gp2oe", pins.gp2_oe, s == 2);
      chk("drive", s == 1 ? pins.clk_o : s == 2 ? pins.gp2_o : pins.int_o, 1);
    end
    @(posedge clk_i); qsrc <= 0; settle(3); chk("or0", pins.gp2_o, 0);
    wb(1, ADDR_QCTRL, 32'h0101); qsrc <= 6'h3E; settle(3);
    chk("srcmask", pins.gp2_o, 0);
    @(posedge clk_i); qsrc <= 6'h01; settle(3);
    chk("srcone", pins.gp2_o, 1);
    wb(1, ADDR_QCTRL, 32'h3F00); wb(1, ADDR_CTRL, 0);
    repeat (4) begin
      @(posedge clk_i); drdy <= $urandom; settle(3); chk("drdy", pins.int_o, drdy);
    end
    close_out;
  end
endmodule
